// >>> inc/pcw_cfg.svh
// Purpose: constants for the pattern cycle watchdog block
// Assumes: 100 MHz core clock
// Notes: offsets, codes, reset values and timing figures live here, though the bench writes register offsets as literals
`ifndef PCW_CFG_SVH
`define PCW_CFG_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define PCW_CDN_ADDR 8'h15
`define PCW_RD_UNMAPPED 8'h00

// ------------------------------------------------------------
// countdown codes and reset values
// ------------------------------------------------------------
`define PCW_CODE_EXPIRED 8'h00
`define PCW_CODE_HOLD 8'hFF
`define PCW_RST_AUTO 8'h40
`define PCW_RST_OFF 8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PCW_CLK_HZ 100000000
`define PCW_MUX_FREQ_HZ 20800
`define PCW_MUX_DUTY_PCT 25
`define PCW_PHASES 4
`define PCW_SLOTS 8
`define PCW_SLOT_CYC_DFLT 1000

`endif

// >>> inc/pcw_pkg.sv
// Purpose: shared types for the pattern cycle watchdog block
// Assumes: constants come from pcw_cfg.svh
// Notes: register requests travel as one packed struct
package pcw_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } pcw_req_t;

  typedef enum logic [1:0] {
    PCW_ST_EXPIRED = 2'b01,
    PCW_ST_RUN = 2'b10
  } pcw_state_t;

endpackage

// >>> hw/pcw_mux_phase.sv
// Purpose: rotates the four multiplex phases of the led bus
// Assumes: PHASE_CYC is one quarter of the multiplex period in clocks
// Notes: one phase active at a time, each for an equal share
`timescale 1ns/100ps
`include "pcw_cfg.svh"
module pcw_mux_phase #(
  parameter int PHASE_CYC = 1201
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [3:0] phase
);

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [3:0] phase_ff;
  logic [3:0] nxt_phase;
  logic tick;

  // ------------------------------------------------------------
  // phase rotation
  // ------------------------------------------------------------
  always_comb begin
    tick = (cnt_ff == 16'(PHASE_CYC - 1));
    nxt_cnt = tick ? 16'h0000 : cnt_ff + 16'h0001;
    // (R07) equal quarter share
    nxt_phase = tick ? {phase_ff[2:0], phase_ff[3]} : phase_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      phase_ff <= 4'h1;
    end else begin
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
    end
  end

  assign phase = phase_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_phase_onehot: assert property ( // (R07)
    @(posedge clk) disable iff (!rst_n) $onehot(phase_ff))
    else $error("mux phase not one-hot");
  a_phase_rotate: assert property ( // (R07)
    @(posedge clk) disable iff (!rst_n)
    tick |=> phase_ff == {$past(phase_ff[2:0]), $past(phase_ff[3])})
    else $error("mux phase did not rotate");
  a_phase_dwell: assert property ( // (R07)
    @(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(phase_ff))
    else $error("mux phase moved early");

endmodule

// >>> hw/pcw_top.sv
// Purpose: pattern cycle countdown with slot stepping and led multiplexing
// Assumes: REG_REQ carries decoded bytes from the serial host interface
// Notes: AUTO_START picks the variant that runs a pattern from reset
// Notes on behaviour
// (R01) eight-bit count of remaining pattern cycles
// (R02) zero count means watchdog expired
// (R03) all-ones code holds, never counts down
// (R04) reset loads 64 or zero by variant
// (R05) host writes the countdown register twice
// (R06) second write transfers count, every write acknowledged
// (R07) multiplex at 20.8kHz, quarter duty phases
// (R08) decrement per finished cycle, stop at zero
// (R09) eight slots, set bit lights rgb
`timescale 1ns/100ps
`include "pcw_cfg.svh"
module pcw_top
  import pcw_pkg::*;
#(
  parameter bit AUTO_START = 1'b0,
  parameter int SLOT_CYC = `PCW_SLOT_CYC_DFLT,
  parameter int MUX_PERIOD_CYC = `PCW_CLK_HZ / `PCW_MUX_FREQ_HZ
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire pcw_req_t REG_REQ,
  input wire logic [31:0] SLOT_MAP,
  output logic REG_ACK,
  output logic [7:0] REG_RDATA,
  output logic PATTERN_RUN,
  output logic [2:0] SLOT_IDX,
  output logic [3:0] RGB_ON,
  output logic [3:0] MUX_PHASE,
  output logic [3:0] LED_EN
);

  localparam int PHASE_CYC = MUX_PERIOD_CYC * `PCW_MUX_DUTY_PCT / 100;
  // (R04) variant reset value
  localparam logic [7:0] CDN_RST = AUTO_START ? `PCW_RST_AUTO : `PCW_RST_OFF;

  logic wr_cdn;
  logic rd_cdn;
  logic load;
  logic cyc_end;
  logic [3:0] phase;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  logic ack_ff;
  logic nxt_ack;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic pend_ff;
  logic nxt_pend;
  logic [7:0] cdn_ff;

  always_comb begin
    wr_cdn = REG_REQ.wr && (REG_REQ.addr == `PCW_CDN_ADDR);
    rd_cdn = REG_REQ.rd && (REG_REQ.addr == `PCW_CDN_ADDR);
    // (R06) acknowledge each byte
    nxt_ack = REG_REQ.wr || REG_REQ.rd;
    nxt_rdata = rdata_ff;
    if (REG_REQ.rd) begin
      nxt_rdata = rd_cdn ? cdn_ff : `PCW_RD_UNMAPPED;
    end
    // (R06) pair the repeated write
    // (R05) relies on host repeating
    load = wr_cdn && pend_ff;
    nxt_pend = pend_ff;
    if (wr_cdn) begin
      nxt_pend = !pend_ff;
    end else if (REG_REQ.wr) begin
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      pend_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      pend_ff <= nxt_pend;
    end
  end

  // ------------------------------------------------------------
  // pattern sequencing
  // ------------------------------------------------------------
  pcw_state_t state_ff;
  pcw_state_t nxt_state;
  logic [7:0] nxt_cdn;
  logic [15:0] slot_cnt_ff;
  logic [15:0] nxt_slot_cnt;
  logic [2:0] slot_ff;
  logic [2:0] nxt_slot;
  logic slot_end;

  always_comb begin
    slot_end = (state_ff == PCW_ST_RUN) && (slot_cnt_ff == 16'(SLOT_CYC - 1));
    // (R09) eight slots per cycle
    cyc_end = slot_end && (slot_ff == 3'(`PCW_SLOTS - 1));
    nxt_cdn = cdn_ff;
    // load wins: a fresh count from the host replaces the pending step
    if (load) begin
      // (R01) count taken from host
      nxt_cdn = REG_REQ.data;
    end else if (cyc_end && cdn_ff != `PCW_CODE_HOLD
                 && cdn_ff != `PCW_CODE_EXPIRED) begin
      // (R08) one step per cycle
      // (R03) hold code skipped here
      nxt_cdn = cdn_ff - 8'h01;
    end
    // (R02) zero stops the pattern
    nxt_state = (nxt_cdn == `PCW_CODE_EXPIRED) ? PCW_ST_EXPIRED : PCW_ST_RUN;
    nxt_slot_cnt = 16'h0000;
    nxt_slot = 3'h0;
    if (state_ff == PCW_ST_RUN && nxt_state == PCW_ST_RUN) begin
      nxt_slot_cnt = slot_end ? 16'h0000 : slot_cnt_ff + 16'h0001;
      nxt_slot = slot_end ? slot_ff + 3'h1 : slot_ff;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cdn_ff <= CDN_RST;
      state_ff <= AUTO_START ? PCW_ST_RUN : PCW_ST_EXPIRED;
      slot_cnt_ff <= 16'h0000;
      slot_ff <= 3'h0;
    end else begin
      cdn_ff <= nxt_cdn;
      state_ff <= nxt_state;
      slot_cnt_ff <= nxt_slot_cnt;
      slot_ff <= nxt_slot;
    end
  end

  // ------------------------------------------------------------
  // rgb selection and multiplexing
  // ------------------------------------------------------------
  pcw_mux_phase #(
    .PHASE_CYC(PHASE_CYC)
  ) u_mux (
    .clk(CLK),
    .rst_n(RST_N),
    .phase(phase)
  );

  logic [3:0] rgb_ff;
  logic [3:0] nxt_rgb;
  logic [3:0] led_ff;
  logic [3:0] nxt_led;
  logic [3:0] phase_ff;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rgb
      // (R09) slot bit lights rgb
      always_comb begin
        nxt_rgb[g] = (nxt_state == PCW_ST_RUN) && SLOT_MAP[g * 8 + int'(nxt_slot)];
      end
    end
  endgenerate

  always_comb begin
    // (R07) each rgb only in its phase
    nxt_led = nxt_rgb & phase;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rgb_ff <= 4'h0;
      led_ff <= 4'h0;
      phase_ff <= 4'h1;
    end else begin
      rgb_ff <= nxt_rgb;
      led_ff <= nxt_led;
      phase_ff <= phase;
    end
  end

  assign REG_ACK = ack_ff;
  assign REG_RDATA = rdata_ff;
  // run is the one-hot run bit itself, so the pin comes straight off a flop
  assign PATTERN_RUN = state_ff[1];
  assign SLOT_IDX = slot_ff;
  assign RGB_ON = rgb_ff;
  assign MUX_PHASE = phase_ff;
  assign LED_EN = led_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_ack_next_cycle: assert property ( // (R06)
    (REG_REQ.wr || REG_REQ.rd) |=> REG_ACK ##1 !REG_ACK || $past(REG_REQ.wr || REG_REQ.rd))
    else $error("byte not acknowledged next cycle");
  a_second_write_loads: assert property ( // (R06)
    (wr_cdn && pend_ff) |=> cdn_ff == $past(REG_REQ.data) && !pend_ff)
    else $error("second write did not load count");
  a_first_write_keeps: assert property ( // (R05)
    (wr_cdn && !pend_ff && !cyc_end) |=> $stable(cdn_ff) && pend_ff)
    else $error("single write changed count");
  a_hold_code_stays: assert property ( // (R03)
    (cdn_ff == `PCW_CODE_HOLD && !load) |=> cdn_ff == `PCW_CODE_HOLD)
    else $error("hold code counted down");
  a_expired_stops: assert property ( // (R02)
    (cdn_ff == `PCW_CODE_EXPIRED && !load) |=> !PATTERN_RUN && RGB_ON == 4'h0)
    else $error("pattern ran while expired");
  a_cycle_decrement: assert property ( // (R08)
    (cyc_end && !load && cdn_ff != `PCW_CODE_HOLD && cdn_ff != `PCW_CODE_EXPIRED)
    |=> cdn_ff == $past(cdn_ff) - 8'h01)
    else $error("count missed its step");
  a_no_step_midcycle: assert property ( // (R01)
    (!cyc_end && !load) |=> $stable(cdn_ff))
    else $error("count moved between cycle ends");
  a_read_returns_count: assert property ( // (R01)
    rd_cdn |=> REG_RDATA == $past(cdn_ff))
    else $error("read did not return count");
  a_led_in_phase: assert property ( // (R07)
    (LED_EN & ~MUX_PHASE) == 4'h0 && $onehot(MUX_PHASE))
    else $error("led driven outside its phase");
  a_rgb_follows_map: assert property ( // (R09)
    PATTERN_RUN && $past(RST_N) |->
    RGB_ON == {SLOT_MAP[24 + int'(SLOT_IDX)], SLOT_MAP[16 + int'(SLOT_IDX)],
                               SLOT_MAP[8 + int'(SLOT_IDX)], SLOT_MAP[int'(SLOT_IDX)]}
    || $changed(SLOT_MAP))
    else $error("rgb does not match slot map");

  c_load_pair: cover property (wr_cdn ##[1:8] wr_cdn);
  c_count_to_zero: cover property (cyc_end && cdn_ff == 8'h01);
  c_hold_cycle: cover property (cyc_end && cdn_ff == `PCW_CODE_HOLD);
  c_slot_wrap: cover property (slot_end && slot_ff == 3'h7);

endmodule

// >>> test/pcw_host_model.sv
// Purpose: host model issuing decoded register requests
// Assumes: one byte per request pulse, ack one cycle later
// Notes: after a transfer the idle bus shows inverted address and data
`timescale 1ns/100ps
`include "pcw_cfg.svh"
module pcw_host
  import pcw_pkg::*;
(
  input wire logic clk,
  input wire logic ack,
  input wire logic [7:0] rdata,
  output pcw_req_t req
);
  // ------------------------------------------------------------
  // transfers
  // ------------------------------------------------------------
  initial begin
    req = '0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic k, output logic [7:0] q);
    @(posedge clk);
    #1;
    req = '{w, !w, a, d};
    @(posedge clk);
    #1;
    // stale bytes must never pass for a held request
    req = '{1'b0, 1'b0, ~a, ~d};
    k = ack;
    q = rdata;
  endtask

  task automatic pair(input logic [7:0] d, output logic k);
    logic k1;
    logic [7:0] q;
    xfer(1'b1, `PCW_CDN_ADDR, d, k1, q);
    xfer(1'b1, `PCW_CDN_ADDR, d, k, q);
    k = k & k1;
  endtask
endmodule

// >>> test/tb_pattern_cycle_watchdog.sv
// Purpose: bench for the pattern cycle watchdog
// Assumes: short slot and mux counts keep the run brief
// Notes: auto-start variant, so the count starts at 64
`timescale 1ns/100ps
`include "pcw_cfg.svh"
module tb_pattern_cycle_watchdog
  import pcw_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] map = 32'hA5C30F81;
  pcw_req_t req;
  logic ack, run, run_off;
  logic [7:0] rdata, rdata_off, seen, hl;
  logic [2:0] sidx;
  logic [3:0] rgb, ph, led, pph;
  int fail_count = 0;
  int cmp_count = 0;
  int n;

  always #5 clk = ~clk;

  pcw_top #(.AUTO_START(1'b1), .SLOT_CYC(4), .MUX_PERIOD_CYC(8)) u_dut (
    .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .SLOT_MAP(map), .REG_ACK(ack),
    .REG_RDATA(rdata), .PATTERN_RUN(run), .SLOT_IDX(sidx), .RGB_ON(rgb),
    .MUX_PHASE(ph), .LED_EN(led));
  // disabled variant shares the host bus, only its reset state is checked
  pcw_top #(.AUTO_START(1'b0), .SLOT_CYC(4), .MUX_PERIOD_CYC(8)) u_dut_off (
    .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .SLOT_MAP(map), .REG_ACK(),
    .REG_RDATA(rdata_off), .PATTERN_RUN(run_off), .SLOT_IDX(), .RGB_ON(),
    .MUX_PHASE(), .LED_EN());
  pcw_host u_host (.clk(clk), .ack(ack), .rdata(rdata), .req(req));

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask

  // reads pass the expected byte in d
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic k;
    logic [7:0] q;
    u_host.xfer(w, a, d, k, q);
    chk8("ack", 8'h01, {7'h00, k});
    if (!w) chk8("rdata", d, q);
  endtask

  task automatic ld(input logic [7:0] d);
    logic k;
    u_host.pair(d, k);
    chk8("pair ack", 8'h01, {7'h00, k});
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // tests need some 260 cycles; 1000 cycles leaves margin for a hang
  initial begin
    #10000;
    fail_count++;
    final_report();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk8("run", 8'h01, {7'h00, run});
    chk8("run off", 8'h00, {7'h00, run_off});
    op(1'b0, `PCW_CDN_ADDR, `PCW_RST_AUTO);
    chk8("count off", `PCW_RST_OFF, rdata_off);
    op(1'b0, 8'h10, 8'h00);
    $display("test reset done");
    ld(`PCW_CODE_EXPIRED);
    chk8("run", 8'h00, {7'h00, run});
    op(1'b1, 8'h15, 8'h03);
    op(1'b1, 8'h10, 8'h03);
    op(1'b1, 8'h15, 8'h03);
    op(1'b0, 8'h15, 8'h00);
    op(1'b1, 8'h15, 8'h03);
    op(1'b0, 8'h15, 8'h03);
    n = 0;
    while (run === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8("run time", 8'h01, {7'h00, n >= 90 && n <= 97});
    repeat (40) @(posedge clk);
    #1;
    op(1'b0, 8'h15, 8'h00);
    $display("test countdown done");
    ld(`PCW_CODE_HOLD);
    repeat (2) @(posedge clk);
    #1;
    pph = ph;
    seen = 8'h00;
    hl = 8'h00;
    n = 0;
    repeat (80) begin
      @(posedge clk);
      #1;
      chk8("rgb", {4'h0, map[24+sidx], map[16+sidx], map[8+sidx], map[sidx]},
           {4'h0, rgb});
      if (ph !== pph) begin
        chk8("phase", {4'h0, pph[2:0], pph[3]}, {4'h0, ph});
        if (n > 0) chk8("phase len", 8'h02, hl);
        n++;
        hl = 8'h00;
      end
      hl++;
      // led, rgb and phase are registered on the same edge
      chk8("led", {4'h0, rgb & ph}, {4'h0, led});
      seen[sidx] = 1'b1;
      pph = ph;
    end
    chk8("slots", 8'hFF, seen);
    op(1'b0, 8'h15, `PCW_CODE_HOLD);
    chk8("run", 8'h01, {7'h00, run});
    $display("test hold done");
    final_report();
  end
endmodule
